// ==== gpde_pkg.sv ====
// package: register map, field layout and carrier types for the port d/e block
package gpde_pkg;

    // register offsets on the plain cpu port (byte addresses)
    localparam logic [7:0] WIDE_DATA_OFS   = 8'h03;
    localparam logic [7:0] NARROW_DATA_OFS = 8'h08;
    localparam logic [7:0] WIDE_DIR_OFS    = 8'h07;
    localparam logic [7:0] NARROW_DIR_OFS  = 8'h0c;
    localparam logic [7:0] PAD_CTRL_OFS    = 8'h0a;

    // widths of the two ports
    localparam int WIDE_W   = 8;
    localparam int NARROW_W = 2;

    // pad control field positions
    localparam int SLOW_LO_BIT = 0;
    localparam int SLOW_HI_BIT = 1;
    localparam int PU_LO_BIT   = 2;
    localparam int PU_HI_BIT   = 3;
    localparam int PAD_CTRL_W  = 4;

    // reset values of the direction and control registers
    localparam logic [7:0] WIDE_DIR_RST   = 8'h00;
    localparam logic [1:0] NARROW_DIR_RST = 2'h0;
    localparam logic [3:0] PAD_CTRL_RST   = 4'h0;

    // pin positions that carry alternate functions
    localparam int PIN_SER_TX  = 6;
    localparam int PIN_SER_RX  = 7;
    localparam int PIN_TMR_CH0 = 4;
    localparam int PIN_TMR_CH1 = 5;

    // one peripheral override for a single pin
    typedef struct packed {
        logic own;    // peripheral takes the pin
        logic drive;  // peripheral output enable
        logic value;  // peripheral output level
    } gpde_ovr_t;

    // one cpu port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gpde_req_t;

endpackage

// ==== gpde_pin.sv ====
// one port pin: override mux, open-drain choice and input synchroniser
`timescale 1ns/1ps
`default_nettype none
module gpde_pin (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // port controls
    input  wire logic              latchValue,
    input  wire logic              dirOut,
    input  wire logic              openDrain,
    input  var  gpde_pkg::gpde_ovr_t ovr,
    // pad
    input  wire logic              padIn,
    output logic                   padOut,
    output logic                   padOe,
    // synchronised level
    output logic                   level
);
    logic sync1;
    logic sync2;
    logic drv;
    logic val;

    // two stages before anything reads the pad
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= padIn;
            sync2 <= sync1;
        end
    end
    assign level = sync2;

    // peripheral overrides port latch and direction; the open-drain choice still applies
    assign drv = ovr.own ? ovr.drive : dirOut;   // see [R02]
    assign val = ovr.own ? ovr.value : latchValue;
    // open drain only sinks, so a high level releases the pad
    assign padOe  = openDrain ? (drv & ~val) : drv;   // see [R07]
    assign padOut = openDrain ? 1'b0 : val;
endmodule
`default_nettype wire

// ==== gpde_ports.sv ====
// wide and narrow general-purpose ports with register port and pin overrides
// How it works
// [R01] wide data latches survive reset untouched
// [R02] direction one drives pin, zero is input
// [R03] reset clears all wide direction bits
// [R04] output pins read back their latch
// [R05] input pins read back synchronised pin level
// [R06] latch writes always accepted, pin unaffected
// [R07] slow-edge bit makes pins 6/7 open drain
// [R08] pull-up bit connects pull-up regardless direction
// [R09] serial enable gives pins 6/7 to serial
// [R10] timer one selects own pins 4 and 5
// [R11] option bit routes two-wire lines to 6/7
// [R12] narrow port: kept latches, cleared directions
// [R13] narrow reads mix latch and pin level
// [R14] timer two selects own narrow pins
// [R15] software loads latch before turning output
// [R16] converter pins need input mode, others off
// [R17] unused narrow bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
module gpde_ports (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset,
    // cpu register port
    input  var  gpde_pkg::gpde_req_t req,
    output logic [7:0]               rdata,
    // wide port pads
    input  wire logic [7:0]          widePadIn,
    output logic [7:0]               widePadOut,
    output logic [7:0]               widePadOe,
    output logic [1:0]               upperPinPullup,
    // narrow port pads
    input  wire logic [1:0]          narrowPadIn,
    output logic [1:0]               narrowPadOut,
    output logic [1:0]               narrowPadOe,
    // async serial
    input  wire logic                asyncSerialEnable,
    input  wire logic                serialTx,
    output logic                     serialRx,
    // timers: select nonzero means timer owns the pin
    input  wire logic [1:0]          timerOneSelZero,
    input  wire logic [1:0]          timerOneSelOne,
    input  wire logic [1:0]          timerTwoSelZero,
    input  wire logic [1:0]          timerTwoSelOne,
    input  wire logic [3:0]          timerChanOe,
    input  wire logic [3:0]          timerChanOut,
    output logic [3:0]               timerChanIn,
    // two-wire interface, open drain lines
    input  wire logic                optionTwoWireOnWide,
    input  wire logic                twoWireDataLow,
    input  wire logic                twoWireClockLow,
    output logic                     twoWireDataIn,
    output logic                     twoWireClockIn
);
    // register state
    logic [7:0] wideData;
    logic [7:0] wideDir;
    logic [1:0] narrowData;
    logic [1:0] narrowDir;
    logic [3:0] padCtrl;
    logic [7:0] next_wideData;
    logic [7:0] next_wideDir;
    logic [1:0] next_narrowData;
    logic [1:0] next_narrowDir;
    logic [3:0] next_padCtrl;
    logic [7:0] next_rdata;

    // pin side
    logic [7:0]          wideLevel;
    logic [1:0]          narrowLevel;
    gpde_pkg::gpde_ovr_t wideOvr [8];
    gpde_pkg::gpde_ovr_t narrowOvr [2];
    logic [7:0]          wideOd;

    // mixed read: latch for outputs, pin for inputs
    function automatic logic [7:0] mixRead(input logic [7:0] lat, input logic [7:0] dir,
                                           input logic [7:0] lvl);
        mixRead = (lat & dir) | (lvl & ~dir);
    endfunction

    // a timer select of zero leaves the pin to the port
    function automatic logic timerOwns(input logic [1:0] sel);
        timerOwns = |sel;
    endfunction

    // the fixed slices below serve only this layout, so refuse any other
    if (gpde_pkg::WIDE_W != 8 || gpde_pkg::NARROW_W != 2 ||
        gpde_pkg::PAD_CTRL_W != 4) begin : gLayoutCheck
        $error("port layout constants do not fit the fixed slices");
    end

    // data latches have no reset, so they live apart
    always_ff @(posedge clk_sys) begin
        wideData   <= next_wideData;     // see [R01]
        narrowData <= next_narrowData;   // see [R12]
    end

    // direction and control registers, cleared by reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wideDir   <= gpde_pkg::WIDE_DIR_RST;     // see [R03]
            narrowDir <= gpde_pkg::NARROW_DIR_RST;   // see [R12]
            padCtrl   <= gpde_pkg::PAD_CTRL_RST;
        end else begin
            wideDir   <= next_wideDir;
            narrowDir <= next_narrowDir;
            padCtrl   <= next_padCtrl;
        end
    end

    // read data register, cleared so an idle bus reads zero
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // register writes
    always_comb begin
        next_wideData   = wideData;
        next_wideDir    = wideDir;
        next_narrowData = narrowData;
        next_narrowDir  = narrowDir;
        next_padCtrl    = padCtrl;
        if (req.wr) begin
            unique case (req.addr)
                gpde_pkg::WIDE_DATA_OFS:   next_wideData = req.wdata;   // see [R06]
                gpde_pkg::WIDE_DIR_OFS:    next_wideDir = req.wdata;    // see [R02]
                gpde_pkg::NARROW_DATA_OFS: next_narrowData = req.wdata[1:0];   // see [R17]
                gpde_pkg::NARROW_DIR_OFS:  next_narrowDir = req.wdata[1:0];
                gpde_pkg::PAD_CTRL_OFS:    next_padCtrl = req.wdata[3:0];
                default:                   next_padCtrl = padCtrl;
            endcase
        end
    end

    // read mux; a pin change needs two clocks of sync before it shows here
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                gpde_pkg::WIDE_DATA_OFS:
                    next_rdata = mixRead(wideData, wideDir, wideLevel);   // see [R04] [R05]
                gpde_pkg::WIDE_DIR_OFS:
                    next_rdata = wideDir;
                gpde_pkg::NARROW_DATA_OFS:
                    next_rdata = mixRead({6'h00, narrowData}, {6'h00, narrowDir},
                                         {6'h00, narrowLevel});   // see [R13] [R17]
                gpde_pkg::NARROW_DIR_OFS:
                    next_rdata = {6'h00, narrowDir};
                gpde_pkg::PAD_CTRL_OFS:
                    next_rdata = {4'h0, padCtrl};
                default:
                    next_rdata = 8'h00;
            endcase
        end
    end

    // wide port overrides; serial wins over two-wire on the upper pins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wideOvr[i] = '{own: 1'b0, drive: 1'b0, value: 1'b0};
        end
        wideOvr[4] = '{own: timerOwns(timerOneSelZero), drive: timerChanOe[0],
                       value: timerChanOut[0]};   // see [R10]
        wideOvr[5] = '{own: timerOwns(timerOneSelOne), drive: timerChanOe[1],
                       value: timerChanOut[1]};
        if (asyncSerialEnable) begin
            wideOvr[6] = '{own: 1'b1, drive: 1'b1, value: serialTx};   // see [R09]
            wideOvr[7] = '{own: 1'b1, drive: 1'b0, value: 1'b0};
        end else if (optionTwoWireOnWide) begin
            // two-wire lines only pull low, released high
            wideOvr[6] = '{own: 1'b1, drive: twoWireDataLow, value: 1'b0};   // see [R11]
            wideOvr[7] = '{own: 1'b1, drive: twoWireClockLow, value: 1'b0};
        end
    end

    // narrow port overrides from timer two
    always_comb begin
        narrowOvr[0] = '{own: timerOwns(timerTwoSelZero), drive: timerChanOe[2],
                         value: timerChanOut[2]};   // see [R14]
        narrowOvr[1] = '{own: timerOwns(timerTwoSelOne), drive: timerChanOe[3],
                         value: timerChanOut[3]};
    end

    // slow-edge open drain only on the two upper pins
    always_comb begin
        wideOd    = 8'h00;
        wideOd[6] = padCtrl[gpde_pkg::SLOW_LO_BIT];   // see [R07]
        wideOd[7] = padCtrl[gpde_pkg::SLOW_HI_BIT];
    end

    // pull-ups follow the control bits alone, not the direction
    assign upperPinPullup = {padCtrl[gpde_pkg::PU_HI_BIT], padCtrl[gpde_pkg::PU_LO_BIT]};   // see [R08]

    // peripheral inputs see the synchronised levels
    assign serialRx       = wideLevel[gpde_pkg::PIN_SER_RX];
    assign twoWireDataIn  = wideLevel[gpde_pkg::PIN_SER_TX];
    assign twoWireClockIn = wideLevel[gpde_pkg::PIN_SER_RX];
    assign timerChanIn    = {narrowLevel, wideLevel[gpde_pkg::PIN_TMR_CH1],
                             wideLevel[gpde_pkg::PIN_TMR_CH0]};

    // wide port pins; converter pins 0..3 rely on software leaving them inputs
    for (genvar g = 0; g < 8; g++) begin : gWide
        gpde_pin uPin (
            .clk_sys    (clk_sys),
            .reset      (reset),
            .latchValue (wideData[g]),
            .dirOut     (wideDir[g]),   // see [R16]
            .openDrain  (wideOd[g]),
            .ovr        (wideOvr[g]),
            .padIn      (widePadIn[g]),
            .padOut     (widePadOut[g]),
            .padOe      (widePadOe[g]),
            .level      (wideLevel[g])
        );
    end

    // narrow port pins
    for (genvar g = 0; g < 2; g++) begin : gNarrow
        gpde_pin uPin (
            .clk_sys    (clk_sys),
            .reset      (reset),
            .latchValue (narrowData[g]),
            .dirOut     (narrowDir[g]),
            .openDrain  (1'b0),
            .ovr        (narrowOvr[g]),
            .padIn      (narrowPadIn[g]),
            .padOut     (narrowPadOut[g]),
            .padOe      (narrowPadOe[g]),
            .level      (narrowLevel[g])
        );
    end
endmodule
`default_nettype wire

// ==== gpde_ports_checker.sv ====
// assertion checker for the port d/e block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module gpde_ports_checker (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                reset,
    // register port
    input var  gpde_pkg::gpde_req_t req,
    input wire logic [7:0]          rdata,
    // pads
    input wire logic [7:0]          widePadIn,
    input wire logic [7:0]          widePadOut,
    input wire logic [7:0]          widePadOe,
    input wire logic [1:0]          upperPinPullup,
    input wire logic [1:0]          narrowPadIn,
    input wire logic [1:0]          narrowPadOe,
    // peripherals
    input wire logic                asyncSerialEnable,
    input wire logic                serialTx,
    input wire logic [1:0]          timerOneSelZero,
    input wire logic [1:0]          timerTwoSelZero,
    input wire logic [3:0]          timerChanOe,
    input wire logic                optionTwoWireOnWide,
    input wire logic                twoWireDataLow,
    input wire logic                twoWireClockLow
);
    logic [7:0] sDir, sLat, expW, expN;
    logic [3:0] sPad;
    logic [1:0] nDir, nLat, quiet;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // latch shadows are not reset, same as the real latches
    always_ff @(posedge clk_sys) begin
        if (req.wr && req.addr == gpde_pkg::WIDE_DATA_OFS) sLat <= req.wdata;
        if (req.wr && req.addr == gpde_pkg::NARROW_DATA_OFS) nLat <= req.wdata[1:0];
    end
    // control shadows; quiet counts cycles with steady pins so sync delay cannot matter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sDir <= 8'h00;
            nDir <= 2'h0;
            sPad <= 4'h0;
            quiet <= 2'h0;
        end else begin
            if (req.wr && req.addr == gpde_pkg::WIDE_DIR_OFS) sDir <= req.wdata;
            if (req.wr && req.addr == gpde_pkg::NARROW_DIR_OFS) nDir <= req.wdata[1:0];
            if (req.wr && req.addr == gpde_pkg::PAD_CTRL_OFS) sPad <= req.wdata[3:0];
            if ($changed({narrowPadIn, widePadIn})) quiet <= 2'h0;
            else if (quiet != 2'h3) quiet <= quiet + 2'h1;
        end
    end
    assign expW = (sLat & sDir) | (widePadIn & ~sDir);
    assign expN = {6'h00, (nLat & nDir) | (narrowPadIn & ~nDir)};
    property p_dir_oe; widePadOe[3:0] == sDir[3:0]; endproperty
    property p_out_latch; (widePadOut[3:0] & sDir[3:0]) == (sLat[3:0] & sDir[3:0]); endproperty
    property p_rd_wide;
        req.rd && req.addr == gpde_pkg::WIDE_DATA_OFS && quiet == 2'h3 |=> rdata == $past(expW);
    endproperty
    property p_rd_narrow;
        req.rd && req.addr == gpde_pkg::NARROW_DATA_OFS && quiet == 2'h3 |=> rdata == $past(expN);
    endproperty
    property p_rd_ndir;
        req.rd && req.addr == gpde_pkg::NARROW_DIR_OFS |=> rdata == {6'h00, $past(nDir)};
    endproperty
    property p_pullup; upperPinPullup == sPad[3:2]; endproperty
    property p_slow;
        !asyncSerialEnable && !optionTwoWireOnWide && sPad[0]
            |-> widePadOe[6] == (sDir[6] && !sLat[6]) && !widePadOut[6];
    endproperty
    property p_serial;
        asyncSerialEnable && !sPad[0] |-> widePadOe[7:6] == 2'b01 && widePadOut[6] == serialTx;
    endproperty
    property p_two_wire;
        optionTwoWireOnWide && !asyncSerialEnable
            |-> widePadOe[7:6] == {twoWireClockLow, twoWireDataLow};
    endproperty
    property p_timer; widePadOe[4] == (timerOneSelZero != 2'h0 ? timerChanOe[0] : sDir[4]); endproperty
    property p_timer_two;
        narrowPadOe[0] == (timerTwoSelZero != 2'h0 ? timerChanOe[2] : nDir[0]);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("low pin enable wrong");
    a_out_latch: assert property (p_out_latch) else $error("pin level wrong");
    a_rd_wide: assert property (p_rd_wide) else $error("wide read wrong");
    a_rd_narrow: assert property (p_rd_narrow) else $error("narrow read wrong");
    a_rd_ndir: assert property (p_rd_ndir) else $error("narrow dir read wrong");
    a_pullup: assert property (p_pullup) else $error("pull-up wrong");
    a_slow: assert property (p_slow) else $error("slow pin not open drain");
    a_serial: assert property (p_serial) else $error("serial pins wrong");
    a_two_wire: assert property (p_two_wire) else $error("two-wire pins wrong");
    a_timer: assert property (p_timer) else $error("timer one pin wrong");
    a_timer_two: assert property (p_timer_two) else $error("timer two pin wrong");
    // main scenarios reached
    c_rd: cover property (req.rd && req.addr == gpde_pkg::WIDE_DATA_OFS && quiet == 2'h3);
    c_serial: cover property (asyncSerialEnable && serialTx);
    c_slow: cover property (sPad[0] && sDir[6]);
endmodule
bind gpde_ports gpde_ports_checker u_chk (.clk_sys, .reset, .req, .rdata, .widePadIn,
    .widePadOut, .widePadOe, .upperPinPullup, .narrowPadIn, .narrowPadOe, .asyncSerialEnable,
    .serialTx, .timerOneSelZero, .timerTwoSelZero, .timerChanOe, .optionTwoWireOnWide,
    .twoWireDataLow, .twoWireClockLow);
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench for the port d/e block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys, reset, asyncSerialEnable, serialTx, serialRx, optionTwoWireOnWide;
    logic twoWireDataLow, twoWireClockLow, twoWireDataIn, twoWireClockIn;
    logic [7:0] rdata, widePadIn, widePadOut, widePadOe, l, d, p, n;
    logic [1:0] upperPinPullup, narrowPadIn, narrowPadOut, narrowPadOe;
    logic [1:0] timerOneSelZero, timerOneSelOne, timerTwoSelZero, timerTwoSelOne;
    logic [3:0] timerChanOe, timerChanOut, timerChanIn;
    gpde_pkg::gpde_req_t req;
    int fails, tests_run, i;
    gpde_ports u_dut (.clk_sys, .reset, .req, .rdata, .widePadIn, .widePadOut, .widePadOe,
        .upperPinPullup, .narrowPadIn, .narrowPadOut, .narrowPadOe, .asyncSerialEnable,
        .serialTx, .serialRx, .timerOneSelZero, .timerOneSelOne, .timerTwoSelZero,
        .timerTwoSelOne, .timerChanOe, .timerChanOut, .timerChanIn, .optionTwoWireOnWide,
        .twoWireDataLow, .twoWireClockLow, .twoWireDataIn, .twoWireClockIn);
    function automatic logic [7:0] mix(input logic [7:0] lat, dir, pin);
        return (lat & dir) | (pin & ~dir);
    endfunction
    // timer-owned pins follow the channel, the rest follow the port
    function automatic logic [3:0] pick(input logic [1:0] sel, input logic [3:0] tmr, port);
        return (sel != 2'b00) ? tmr : port;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle strobes launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        req <= '0;
        @(negedge clk_sys);
        chk(rdata, exp);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        complete_run();
    end
    initial begin
        {reset, req, asyncSerialEnable, serialTx, optionTwoWireOnWide} = '1;
        {req, asyncSerialEnable, serialTx, optionTwoWireOnWide, twoWireDataLow} = '0;
        {twoWireClockLow, timerOneSelZero, timerOneSelOne, timerTwoSelZero} = '0;
        {timerTwoSelOne, timerChanOe, timerChanOut} = '0;
        widePadIn = 8'h3c;
        narrowPadIn = 2'h1;
        l = 8'($urandom(32'h89b3f53f));
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(gpde_pkg::WIDE_DIR_OFS, 8'h00);
        rd(gpde_pkg::NARROW_DIR_OFS, 8'h00);
        rd(8'h20, 8'h00);
        rd(gpde_pkg::WIDE_DATA_OFS, 8'h3c);
        // random mixes of latch, direction and pin, all-in and all-out first
        for (i = 0; i < 16; i++) begin
            l = 8'($urandom);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            p = 8'($urandom);
            n = 8'($urandom);
            wr(gpde_pkg::WIDE_DATA_OFS, l);
            wr(gpde_pkg::WIDE_DIR_OFS, d);
            wr(gpde_pkg::NARROW_DATA_OFS, n);
            wr(gpde_pkg::NARROW_DIR_OFS, d);
            widePadIn <= p;
            narrowPadIn <= p[7:6];
            repeat (3) @(posedge clk_sys);
            rd(gpde_pkg::WIDE_DATA_OFS, mix(l, d, p));
            rd(gpde_pkg::NARROW_DATA_OFS, mix(n, d, p >> 6) & 8'h03);
            rd(gpde_pkg::NARROW_DIR_OFS, {6'h00, d[1:0]});
            chk({4'h0, widePadOe[3:0]}, {4'h0, d[3:0]});
        end
        // latches survive a reset in mid-run, directions do not
        wr(gpde_pkg::WIDE_DATA_OFS, 8'ha5);
        wr(gpde_pkg::NARROW_DATA_OFS, 8'hfe);
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        rd(gpde_pkg::WIDE_DIR_OFS, 8'h00);
        wr(gpde_pkg::WIDE_DIR_OFS, 8'hff);
        wr(gpde_pkg::NARROW_DIR_OFS, 8'h03);
        rd(gpde_pkg::WIDE_DATA_OFS, 8'ha5);
        rd(gpde_pkg::NARROW_DATA_OFS, 8'h02);
        // slow-edge sink and pull-ups on the upper pins
        wr(gpde_pkg::WIDE_DATA_OFS, 8'h40);
        wr(gpde_pkg::PAD_CTRL_OFS, 8'h0f);
        rd(gpde_pkg::PAD_CTRL_OFS, 8'h0f);
        chk({6'h00, widePadOe[7:6]}, 8'h02);
        chk({6'h00, upperPinPullup}, 8'h03);
        wr(gpde_pkg::PAD_CTRL_OFS, 8'h04);
        @(negedge clk_sys);
        chk({4'h0, upperPinPullup, widePadOe[7:6]}, 8'h07);
        // serial (also over two-wire), then two-wire, then timers with random channels
        for (i = 0; i < 12; i++) begin
            l = 8'($urandom);
            p = 8'($urandom);
            @(posedge clk_sys);
            asyncSerialEnable <= i < 4;
            optionTwoWireOnWide <= i >= 2 && i < 8;
            serialTx <= i[0];
            {twoWireClockLow, twoWireDataLow} <= i[1:0];
            widePadIn <= {i[1], i[0], p[1:0], widePadIn[3:0]};
            narrowPadIn <= p[3:2];
            {timerOneSelZero, timerOneSelOne, timerTwoSelZero, timerTwoSelOne} <= {4{i[1:0]}};
            {timerChanOe, timerChanOut} <= l;
            repeat (3) @(negedge clk_sys);
            if (i < 4) begin
                n = {4'h0, serialRx, widePadOut[6], widePadOe[7:6]};
                chk(n, {4'h0, i[1:0], 2'b01});
            end else if (i < 8) begin
                n = {4'h0, twoWireClockIn, twoWireDataIn, widePadOe[7:6]};
                chk(n, {4'h0, i[1:0], i[1:0]});
            end else begin
                n = {narrowPadOe, widePadOe[5:4], narrowPadOut, widePadOut[5:4]};
                d = {pick(i[1:0], l[7:4], 4'hf), pick(i[1:0], l[3:0], 4'h8)};
                chk(n, d);
            end
            chk({4'h0, timerChanIn}, {4'h0, p[3:0]});
        end
        complete_run();
    end
endmodule
`default_nettype wire
